// File: hw/aegc_defs.svh
// register offsets, field widths, reset values and limits of the exposure/gain config bank
`ifndef AEGC_DEFS_SVH
`define AEGC_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define AEGC_OFF_MAN_GAIN 12'h004
`define AEGC_OFF_ANA_OFFSET 12'h008
`define AEGC_OFF_GAIN_HI 12'h160
`define AEGC_OFF_WIN_W 12'h164
`define AEGC_OFF_WIN_X 12'h168
`define AEGC_OFF_WIN_H 12'h16c
`define AEGC_OFF_WIN_Y 12'h170
`define AEGC_OFF_AE_SPEED 12'h174
`define AEGC_OFF_AG_SPEED 12'h178
`define AEGC_OFF_METER 12'h17c
`define AEGC_OFF_GAIN_LO 12'h18c
`define AEGC_OFF_EXP_HI 12'h5b0
`define AEGC_OFF_EXP_LO 12'h5c8
`define AEGC_OFF_STATUS 12'h5cc
`define AEGC_OFF_CTRL 12'h5d0

// ---------------------------------------------------------------
// field widths and limits
// ---------------------------------------------------------------
`define AEGC_GAIN_W 9
`define AEGC_WIN_W 11
`define AEGC_SPEED_W 2
`define AEGC_GAIN_MAX 9'h1e0
`define AEGC_WIN_W_MAX 11'h780
`define AEGC_WIN_H_MAX 11'h438
`define AEGC_EXP_LONGEST 11'h006
`define AEGC_EXP_SHORTEST 11'h464
`define AEGC_EXP_PER_FRAME 11'h45e

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AEGC_RST_GAIN_HI 9'h1e0
`define AEGC_RST_GAIN_LO 9'h000
`define AEGC_RST_WIN_W 11'h780
`define AEGC_RST_WIN_H 11'h438
`define AEGC_RST_EXP_HI 11'h006
`define AEGC_RST_EXP_LO 11'h464

`endif

// File: hw/aegc_pkg.sv
// types shared by the exposure/gain config bank
package aegc_pkg;
  typedef enum logic [1:0] {
    AEGC_METER_AVERAGE = 2'h0,
    AEGC_METER_PEAK = 2'h1,
    AEGC_METER_RSVD2 = 2'h2,
    AEGC_METER_RSVD3 = 2'h3
  } aegc_meter_t;

  typedef struct packed {
    logic [10:0] x_start;
    logic [10:0] y_start;
    logic [10:0] width;
    logic [10:0] height;
  } aegc_window_t;

  typedef struct packed {
    logic [8:0] gain_lo;
    logic [8:0] gain_hi;
    logic [10:0] exp_lo;
    logic [10:0] exp_hi;
  } aegc_limits_t;

  typedef struct packed {
    logic [8:0] gain;
    logic [10:0] exposure;
  } aegc_applied_t;
endpackage : aegc_pkg

// File: hw/aegc_config.sv
// exposure/gain control register bank with APB slave and window / limit clamping
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "aegc_defs.svh"

module aegc_config #(
  parameter int unsigned FRAME_ROWS = 1080
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic pix_valid_in,
  input wire logic [10:0] pix_col_in,
  input wire logic [10:0] pix_row_in,
  input wire aegc_pkg::aegc_applied_t loop_req_in,
  output logic pix_in_window_out,
  output aegc_pkg::aegc_applied_t applied_out,
  output aegc_pkg::aegc_meter_t meter_out,
  output logic [1:0] ae_speed_out,
  output logic [1:0] ag_speed_out,
  output logic [2:0] ae_rate_out,
  output logic [2:0] ag_rate_out,
  output logic [8:0] manual_gain_out,
  output logic [8:0] analog_offset_out,
  output logic auto_enable_out
);
  import aegc_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [8:0] man_gain;
  logic [8:0] ana_offset;
  aegc_limits_t lim;
  aegc_window_t win;
  logic [1:0] ae_speed;
  logic [1:0] ag_speed;
  aegc_meter_t meter;
  logic auto_en;
  logic sat_gain;
  logic sat_exp;
  logic [31:0] next_rdata;
  logic wr_go;
  logic rd_go;
  logic hit;

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  function automatic logic in_span(input logic [10:0] pos, input logic [10:0] start,
                                   input logic [10:0] len);
    logic [11:0] end_pos;
    end_pos = {1'b0, start} + {1'b0, len};
    return ({1'b0, pos} >= {1'b0, start}) && ({1'b0, pos} < end_pos);
  endfunction : in_span

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign wr_go = psel_in && penable_in && pwrite_in && pready_out;
  assign rd_go = psel_in && !penable_in && !pwrite_in;

  always_comb begin
    hit = 1'b1;
    next_rdata = 32'h0000_0000;
    unique case (paddr_in)
      `AEGC_OFF_MAN_GAIN: next_rdata[8:0] = man_gain;
      `AEGC_OFF_ANA_OFFSET: next_rdata[8:0] = ana_offset;
      `AEGC_OFF_GAIN_HI: next_rdata[8:0] = lim.gain_hi;
      `AEGC_OFF_GAIN_LO: next_rdata[8:0] = lim.gain_lo;
      `AEGC_OFF_WIN_W: next_rdata[10:0] = win.width;
      `AEGC_OFF_WIN_X: next_rdata[10:0] = win.x_start;
      `AEGC_OFF_WIN_H: next_rdata[10:0] = win.height;
      `AEGC_OFF_WIN_Y: next_rdata[10:0] = win.y_start;
      `AEGC_OFF_AE_SPEED: next_rdata[1:0] = ae_speed;
      `AEGC_OFF_AG_SPEED: next_rdata[1:0] = ag_speed;
      `AEGC_OFF_METER: next_rdata[1:0] = meter;
      `AEGC_OFF_EXP_HI: next_rdata[10:0] = lim.exp_hi;
      `AEGC_OFF_EXP_LO: next_rdata[10:0] = lim.exp_lo;
      `AEGC_OFF_STATUS: next_rdata[1:0] = {sat_exp, sat_gain};
      `AEGC_OFF_CTRL: next_rdata[0] = auto_en;
      default: hit = 1'b0;
    endcase
  end

  // no wait state: ready rises in the access phase, so every transfer takes two edges
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !hit;
      if (rd_go) begin
        prdata_out <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes; only the documented low bits are kept
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      man_gain <= 9'h000;
      ana_offset <= 9'h000;
      lim.gain_hi <= `AEGC_RST_GAIN_HI;
      lim.gain_lo <= `AEGC_RST_GAIN_LO;
      lim.exp_hi <= `AEGC_RST_EXP_HI;
      lim.exp_lo <= `AEGC_RST_EXP_LO;
      win.width <= `AEGC_RST_WIN_W;
      win.height <= `AEGC_RST_WIN_H;
      win.x_start <= 11'h000;
      win.y_start <= 11'h000;
      ae_speed <= 2'h0;
      ag_speed <= 2'h0;
      meter <= AEGC_METER_AVERAGE;
      auto_en <= 1'b0;
    end else if (wr_go) begin
      unique case (paddr_in)
        `AEGC_OFF_MAN_GAIN: man_gain <= 9'(strb_merge(32'(man_gain), pwdata_in,
          pstrb_in));
        `AEGC_OFF_ANA_OFFSET: ana_offset <= 9'(strb_merge(32'(ana_offset), pwdata_in,
          pstrb_in));
        `AEGC_OFF_GAIN_HI: lim.gain_hi <= 9'(strb_merge(32'(lim.gain_hi), pwdata_in,
          pstrb_in));
        `AEGC_OFF_GAIN_LO: lim.gain_lo <= 9'(strb_merge(32'(lim.gain_lo), pwdata_in,
          pstrb_in));
        `AEGC_OFF_WIN_W: win.width <= 11'(strb_merge(32'(win.width), pwdata_in,
          pstrb_in));
        `AEGC_OFF_WIN_X: win.x_start <= 11'(strb_merge(32'(win.x_start), pwdata_in,
          pstrb_in));
        `AEGC_OFF_WIN_H: win.height <= 11'(strb_merge(32'(win.height), pwdata_in,
          pstrb_in));
        `AEGC_OFF_WIN_Y: win.y_start <= 11'(strb_merge(32'(win.y_start), pwdata_in,
          pstrb_in));
        `AEGC_OFF_AE_SPEED: if (pstrb_in[0]) ae_speed <= pwdata_in[1:0];
        `AEGC_OFF_AG_SPEED: if (pstrb_in[0]) ag_speed <= pwdata_in[1:0];
        `AEGC_OFF_METER: if (pstrb_in[0]) meter <= aegc_meter_t'(pwdata_in[1:0]);
        `AEGC_OFF_EXP_HI: lim.exp_hi <= 11'(strb_merge(32'(lim.exp_hi), pwdata_in,
          pstrb_in));
        `AEGC_OFF_EXP_LO: lim.exp_lo <= 11'(strb_merge(32'(lim.exp_lo), pwdata_in,
          pstrb_in));
        `AEGC_OFF_CTRL: if (pstrb_in[0]) auto_en <= pwdata_in[0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // metering window gate; rows arrive top-down, window y counts from bottom
  // ---------------------------------------------------------------
  logic [10:0] row_from_bottom;
  assign row_from_bottom = 11'(FRAME_ROWS - 1) - pix_row_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pix_in_window_out <= 1'b0;
    end else begin
      pix_in_window_out <= auto_en && pix_valid_in
        && in_span(pix_col_in, win.x_start, win.width)
        && in_span(row_from_bottom, win.y_start, win.height);
    end
  end

  // ---------------------------------------------------------------
  // clamp the loop's request into the limits
  // larger exposure count is a shorter exposure, so the longest-time limit is the smaller count
  // ---------------------------------------------------------------
  logic [10:0] exp_min_cnt;
  logic [10:0] exp_max_cnt;
  logic [8:0] next_gain;
  logic [10:0] next_exp;
  always_comb begin
    exp_min_cnt = (lim.exp_hi < lim.exp_lo) ? lim.exp_hi : lim.exp_lo;
    exp_max_cnt = (lim.exp_hi < lim.exp_lo) ? lim.exp_lo : lim.exp_hi;
    next_gain = loop_req_in.gain;
    if (next_gain > lim.gain_hi) begin
      next_gain = lim.gain_hi;
    end
    if (next_gain < lim.gain_lo) begin
      next_gain = lim.gain_lo;
    end
    next_exp = loop_req_in.exposure;
    if (next_exp < exp_min_cnt) begin
      next_exp = exp_min_cnt;
    end
    if (next_exp > exp_max_cnt) begin
      next_exp = exp_max_cnt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      applied_out <= '0;
      sat_gain <= 1'b0;
      sat_exp <= 1'b0;
    end else if (auto_en) begin
      applied_out.gain <= next_gain;
      applied_out.exposure <= next_exp;
      sat_gain <= next_gain != loop_req_in.gain;
      sat_exp <= next_exp != loop_req_in.exposure;
    end else begin
      applied_out.gain <= man_gain;
      applied_out.exposure <= lim.exp_lo;
      sat_gain <= 1'b0;
      sat_exp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meter_out <= AEGC_METER_AVERAGE;
      ae_speed_out <= 2'h0;
      ag_speed_out <= 2'h0;
      ae_rate_out <= 3'h1;
      ag_rate_out <= 3'h1;
      manual_gain_out <= 9'h000;
      analog_offset_out <= 9'h000;
      auto_enable_out <= 1'b0;
    end else begin
      meter_out <= meter;
      ae_speed_out <= ae_speed;
      ag_speed_out <= ag_speed;
      ae_rate_out <= {1'b0, ae_speed} + 3'h1;
      ag_rate_out <= {1'b0, ag_speed} + 3'h1;
      manual_gain_out <= man_gain;
      analog_offset_out <= ana_offset;
      auto_enable_out <= auto_en;
    end
  end

  // ---------------------------------------------------------------
  // bus and register checks
  // ---------------------------------------------------------------
  sequence s_setup;
    psel_in && !penable_in;
  endsequence

  sequence s_unmapped_read;
    psel_in && !penable_in && !pwrite_in && !hit;
  endsequence

  sequence s_gain_hi_read;
    psel_in && !penable_in && !pwrite_in && paddr_in == `AEGC_OFF_GAIN_HI;
  endsequence

  // write edge, then the register, then the output flop: two edges to the pin
  sequence s_meter_write;
    wr_go && paddr_in == `AEGC_OFF_METER && pstrb_in[0];
  endsequence

  AST_READY_ONE_WAIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_setup |=> pready_out)
    else $error("ready not one cycle after setup");
  AST_UPPER_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pready_out && !pwrite_in && paddr_in != `AEGC_OFF_STATUS |-> prdata_out[31:11] == 21'h0)
    else $error("unused read bits not zero");
  AST_UNMAPPED_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_unmapped_read |=> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped read not refused with zero data");
  AST_GAIN_HI_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_gain_hi_read |=> prdata_out[31:9] == 23'h0
      && prdata_out[8:0] == $past(lim.gain_hi))
    else $error("upper gain limit read back wrong");
  AST_GAIN_LO_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_go && paddr_in == `AEGC_OFF_GAIN_LO && pstrb_in[1:0] == 2'h3
      |=> lim.gain_lo == $past(pwdata_in[8:0]))
    else $error("lower gain limit not stored");
  AST_EXP_HI_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_go && paddr_in == `AEGC_OFF_EXP_HI && pstrb_in[1:0] == 2'h3
      |=> lim.exp_hi == $past(pwdata_in[10:0]))
    else $error("upper exposure limit not stored");
  AST_EXP_LO_STORE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_go && paddr_in == `AEGC_OFF_EXP_LO && pstrb_in[1:0] == 2'h3
      |=> lim.exp_lo == $past(pwdata_in[10:0]))
    else $error("lower exposure limit not stored");
  AST_METER_FOLLOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_meter_write |-> ##2 meter_out == $past(pwdata_in[1:0], 2))
    else $error("metering select not applied");
  AST_RATE_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in |=> ae_rate_out == {1'b0, $past(ae_speed)} + 3'h1)
    else $error("speed code does not map to rate");
  AST_AG_RATE_MAP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in |=> ag_rate_out == {1'b0, $past(ag_speed)} + 3'h1)
    else $error("gain speed code does not map to rate");

  // ---------------------------------------------------------------
  // clamp and window checks
  // ---------------------------------------------------------------
  AST_GAIN_IN_LIMITS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    auto_en && lim.gain_lo <= lim.gain_hi
      |=> applied_out.gain <= $past(lim.gain_hi) && applied_out.gain >= $past(lim.gain_lo))
    else $error("gain outside limits");
  AST_EXP_IN_LIMITS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    auto_en |=> applied_out.exposure >= $past(exp_min_cnt)
      && applied_out.exposure <= $past(exp_max_cnt))
    else $error("exposure outside limits");
  // manual mode is not clamped: software owns the gain it writes
  AST_MANUAL_PATH: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !auto_en && !sys_rst_in |=> applied_out.gain == $past(man_gain)
      && applied_out.exposure == $past(lim.exp_lo))
    else $error("manual values not applied");
  AST_WIN_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !auto_en || !pix_valid_in |=> !pix_in_window_out)
    else $error("window flag without active pixel");
  AST_WIN_X_OUT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pix_col_in < win.x_start |=> !pix_in_window_out)
    else $error("pixel left of window counted");
  AST_WIN_X_END: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    {1'b0, pix_col_in} >= {1'b0, win.x_start} + {1'b0, win.width} |=> !pix_in_window_out)
    else $error("pixel right of window counted");
  AST_WIN_Y_LOW: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    row_from_bottom < win.y_start |=> !pix_in_window_out)
    else $error("pixel below window counted");
  AST_WIN_Y_END: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    {1'b0, row_from_bottom} >= {1'b0, win.y_start} + {1'b0, win.height}
      |=> !pix_in_window_out)
    else $error("pixel above window counted");
endmodule : aegc_config
`default_nettype wire

// File: tb/tb_auto_exposure_gain_config.sv
// self-checking bench for the exposure/gain config bank
`timescale 1ns/1ps
`default_nettype none
`include "aegc_defs.svh"
module tb_auto_exposure_gain_config;
  import aegc_pkg::*;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'h0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, pix_valid_in = 1'b0, pix_in_window_out, auto_enable_out;
  logic [10:0] pix_col_in = 11'h0, pix_row_in = 11'h0;
  aegc_applied_t loop_req_in = '0, applied_out;
  aegc_meter_t meter_out;
  logic [1:0] ae_speed_out, ag_speed_out;
  logic [2:0] ae_rate_out, ag_rate_out;
  logic [8:0] manual_gain_out, analog_offset_out;
  int errors = 0, compares = 0;
  logic [31:0] rd;
  logic er;
  // small frame keeps the bottom-up row arithmetic easy to follow
  aegc_config #(.FRAME_ROWS(16)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .pix_valid_in(pix_valid_in),
    .pix_col_in(pix_col_in), .pix_row_in(pix_row_in), .loop_req_in(loop_req_in),
    .pix_in_window_out(pix_in_window_out), .applied_out(applied_out), .meter_out(meter_out),
    .ae_speed_out(ae_speed_out), .ag_speed_out(ag_speed_out), .ae_rate_out(ae_rate_out),
    .ag_rate_out(ag_rate_out), .manual_gain_out(manual_gain_out),
    .analog_offset_out(analog_offset_out), .auto_enable_out(auto_enable_out));
  always #2 clk_in = ~clk_in;
  // ------------------------------------------------------------
  // register table rows
  // ------------------------------------------------------------
  localparam logic [11:0] ADR [13] = '{`AEGC_OFF_MAN_GAIN, `AEGC_OFF_ANA_OFFSET,
    `AEGC_OFF_GAIN_HI, `AEGC_OFF_WIN_W, `AEGC_OFF_WIN_X, `AEGC_OFF_WIN_H, `AEGC_OFF_WIN_Y,
    `AEGC_OFF_AE_SPEED, `AEGC_OFF_AG_SPEED, `AEGC_OFF_METER, `AEGC_OFF_GAIN_LO,
    `AEGC_OFF_EXP_HI, `AEGC_OFF_EXP_LO};
  localparam logic [31:0] RSTV [13] = '{32'h0, 32'h0, 32'h1e0, 32'h780, 32'h0, 32'h438,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h6, 32'h464};
  localparam logic [31:0] MSK [13] = '{32'h1ff, 32'h1ff, 32'h1ff, 32'h7ff, 32'h7ff, 32'h7ff,
    32'h7ff, 32'h3, 32'h3, 32'h3, 32'h1ff, 32'h7ff, 32'h7ff};
  localparam logic [19:0] REQ [4] = '{{9'h005, 11'h002}, {9'h0c8, 11'h7d0},
    {9'h032, 11'h100}, {9'h1ff, 11'h000}};
  localparam logic [19:0] APL [4] = '{{9'h00a, 11'h006}, {9'h064, 11'h464},
    {9'h032, 11'h100}, {9'h033, 11'h464}};
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // holds the request until pready is sampled high, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w;
    paddr_in <= a; pwdata_in <= d; pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (pready_out === 1'b1) break;
    end
    r = prdata_out;
    e = pslverr_out;
    if (n == 50) chk("pready", 32'h0, 32'h1);
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, rd, er);
  endtask : wr
  task automatic pix(input logic [10:0] c, input logic [10:0] r, input logic exp);
    @(posedge clk_in);
    pix_valid_in <= 1'b1; pix_col_in <= c; pix_row_in <= r;
    @(posedge clk_in);
    pix_valid_in <= 1'b0;
    @(negedge clk_in);
    chk("in_window", {31'h0, pix_in_window_out}, {31'h0, exp});
  endtask : pix
  task automatic settle;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, ADR[i], 32'h0, 4'h0, rd, er);
      chk("reset value", rd, RSTV[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 13; i++) begin
      wr(ADR[i], 32'hffff_ffff);
      apb(1'b0, ADR[i], 32'h0, 4'h0, rd, er);
      chk("all ones", rd, MSK[i]);
      wr(ADR[i], 32'h5a5a_5a5a);
      apb(1'b0, ADR[i], 32'h0, 4'h0, rd, er);
      chk("pattern", rd, 32'h5a5a_5a5a & MSK[i]);
      chk("slverr", {31'h0, er}, 32'h0);
    end
    $display("test register rows done");
    wr(`AEGC_OFF_WIN_W, 32'h0000_07ff);
    apb(1'b1, `AEGC_OFF_WIN_W, 32'h0000_0123, 4'h1, rd, er);
    apb(1'b0, `AEGC_OFF_WIN_W, 32'h0, 4'h0, rd, er);
    chk("byte lane", rd, 32'h0000_0723);
    apb(1'b0, 12'h00c, 32'h0, 4'h0, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test strobe and unmapped done");
    for (int c = 0; c < 4; c++) begin
      wr(`AEGC_OFF_AE_SPEED, 32'(c));
      wr(`AEGC_OFF_AG_SPEED, 32'(3 - c));
      wr(`AEGC_OFF_METER, 32'(c));
      settle();
      chk("ae speed", {30'h0, ae_speed_out}, 32'(c));
      chk("ag speed", {30'h0, ag_speed_out}, 32'(3 - c));
      chk("ae rate", {29'h0, ae_rate_out}, 32'(c + 1));
      chk("ag rate", {29'h0, ag_rate_out}, 32'(4 - c));
      chk("meter", {30'h0, meter_out}, 32'(c));
    end
    $display("test speed and metering codes done");
    wr(`AEGC_OFF_WIN_X, 32'h00a);
    wr(`AEGC_OFF_WIN_W, 32'h005);
    wr(`AEGC_OFF_WIN_Y, 32'h002);
    wr(`AEGC_OFF_WIN_H, 32'h003);
    pix(11'd10, 11'd13, 1'b0);
    wr(`AEGC_OFF_CTRL, 32'h1);
    settle();
    chk("auto enable", {31'h0, auto_enable_out}, 32'h1);
    pix(11'd10, 11'd13, 1'b1);
    pix(11'd14, 11'd11, 1'b1);
    pix(11'd15, 11'd13, 1'b0);
    pix(11'd9, 11'd13, 1'b0);
    pix(11'd12, 11'd10, 1'b0);
    pix(11'd12, 11'd14, 1'b0);
    $display("test metering window done");
    wr(`AEGC_OFF_GAIN_LO, 32'h00a);
    wr(`AEGC_OFF_GAIN_HI, 32'h064);
    wr(`AEGC_OFF_EXP_HI, 32'h006);
    wr(`AEGC_OFF_EXP_LO, 32'h464);
    wr(`AEGC_OFF_MAN_GAIN, 32'h033);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) wr(`AEGC_OFF_CTRL, 32'h0);
      @(posedge clk_in);
      loop_req_in <= REQ[i];
      settle();
      chk("applied", 32'(applied_out), 32'(APL[i]));
      if (i == 0) begin
        apb(1'b0, `AEGC_OFF_STATUS, 32'h0, 4'h0, rd, er);
        chk("clamp status", rd, 32'h3);
      end
    end
    chk("manual gain", {23'h0, manual_gain_out}, 32'h033);
    chk("offset", {23'h0, analog_offset_out}, 32'h05a);
    $display("test clamping done");
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, `AEGC_OFF_GAIN_HI, 32'h0, 4'h0, rd, er);
    chk("rereset gain hi", rd, 32'h1e0);
    chk("rereset rate", {29'h0, ae_rate_out}, 32'h1);
    $display("test second reset done");
    wrap_up();
  end
  // the full sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    wrap_up();
  end
endmodule : tb_auto_exposure_gain_config
`default_nettype wire
